/* rtl/scm_pkg.sv */
// constants, field layout and types for the serial channel mode and baud control block
// Function
// (R1) Wake-up in 9-bit UART passes receive interrupts only when ninth bit is 1.
// (R2) Frame mode field: 00 sync shift, 01/10/11 7/8/9-bit UART.
// (R3) UART clock select: 00 timer, 01 baud generator, 10 fsys, 11 pin.
// (R4) Software sets receive enable only after configuring; never clears mid-frame.
// (R5) Idle-run bit: 0 stops the channel in idle, 1 keeps it running.
// (R6) Sync duplex field: 00 none, 01 receive, 10 transmit, 11 full.
// (R7) Software configures modes before transmit enable; never clears it mid-transmission.
// (R8) Sync double-buffered clock-out gap: none, or 1..64 serial clock periods.
// (R9) Buffer-empty flag resets to 1, sets on shift load, clears on write.
// (R10) Buffer-full flag sets when frame enters double buffer, clears on read.
// (R11) Transmit-active reads 1 while shifting; with empty flag gives status.
// (R12) UART transmits one or two stop bits; receiver checks only one.
// (R13) Bit order 0 LSB-first, 1 MSB-first in sync; UART stays LSB-first.
// (R14) Double-buffer enable; UART or input-clock reception always double-buffered.
// (R15) Writing key 10 then 01 resets enables, flags and shift circuits; the code clears the buffer-empty flag to 0, not 1.
// (R16) During transmission software issues the reset key sequence twice.
// (R17) Software reset takes effect two clocks after the key is recognised.
// (R18) Divider input select: 00 tap 1, 01 tap 4, 10 tap 16, 11 tap 64.
// (R19) Divisor N codes 1..15 direct; code 0 means sixteen.
// (R20) Fractional enable in UART divides by N plus (16-K)/16.
// (R21) Software programs K first, never K zero, never N 1 or 16.
// (R22) Software uses divide ratio 1 only in sync mode with double buffering.
package scm_pkg;

	// register byte offsets
	localparam logic [7:0] SCM_OFF_MODE0 = 8'h0C;
	localparam logic [7:0] SCM_OFF_BAUD  = 8'h10;
	localparam logic [7:0] SCM_OFF_FRAC  = 8'h14;
	localparam logic [7:0] SCM_OFF_MODE1 = 8'h18;
	localparam logic [7:0] SCM_OFF_MODE2 = 8'h1C;

	// field encodings
	localparam logic [1:0] SCM_MODE_SYNC   = 2'h0;
	localparam logic [1:0] SCM_MODE_UART9  = 2'h3;
	localparam logic [1:0] SCM_CLK_BAUD    = 2'h1;
	localparam logic [1:0] SCM_KEY_ARM     = 2'h2;
	localparam logic [1:0] SCM_KEY_FIRE    = 2'h1;
	localparam logic [2:0] SCM_GAP_NONE    = 3'h0;
	localparam logic [3:0] SCM_N_SIXTEEN   = 4'h0;
	localparam logic [4:0] SCM_N_ZERO_VAL  = 5'h10;
	localparam logic [4:0] SCM_FRAC_WRAP   = 5'h10;
	localparam logic [1:0] SCM_HTRANS_NSEQ = 2'h2;
	localparam logic [1:0] SCM_HTRANS_SEQ  = 2'h3;

	// reset values
	localparam logic       SCM_TX_BUFFER_EMPTY_RST = 1'b1;
	localparam logic [7:0] SCM_BYTE_ZERO = 8'h00;

	// soft reset sequencer, one-hot
	typedef enum logic [3:0]
	{
		SCM_SR_IDLE   = 4'b0001,
		SCM_SR_ARMED  = 4'b0010,
		SCM_SR_WAIT1  = 4'b0100,
		SCM_SR_WAIT2  = 4'b1000
	} scm_sr_type;

endpackage

/* rtl/scm_ctrl.sv */
// serial channel mode, status, soft reset and baud divider control with ahb-lite registers
`timescale 1ns/1ps
module scm_ctrl
	import scm_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// system side
	input  wire logic        idle_mode,
	input  wire logic        tap_t1,
	input  wire logic        tap_t4,
	input  wire logic        tap_t16,
	input  wire logic        tap_t64,
	input  wire logic        sclk_input_sel,
	// shift engine events
	input  wire logic        tx_buffer_write,
	input  wire logic        tx_shift_load,
	input  wire logic        tx_shifting,
	input  wire logic        rx_frame_done,
	input  wire logic        rx_ninth_bit,
	// shift engine configuration
	output logic [1:0]       frame_mode,
	output logic [1:0]       uart_clock_select,
	output logic [1:0]       duplex_select,
	output logic             tx_run_enable,
	output logic             rx_run_enable,
	output logic             channel_run,
	output logic             tx_two_stop_bits,
	output logic             msb_first,
	output logic             tx_double_buffered,
	output logic             rx_double_buffered,
	output logic [6:0]       tx_gap_periods,
	output logic             baud_tick,
	output logic             rx_irq,
	output logic             engine_reset
);

	// whole block state
	typedef struct packed
	{
		logic        receive_enable;
		logic        wake_up_enable;
		logic [1:0]  frame_mode;
		logic [1:0]  uart_clock_select;
		logic        idle_run;
		logic [1:0]  duplex_select;
		logic        transmit_enable;
		logic [2:0]  tx_gap_interval;
		logic        tx_buffer_empty;
		logic        rx_buffer_full;
		logic        tx_active;
		logic        stop_length;
		logic        bit_order;
		logic        double_buffer_enable;
		logic [1:0]  soft_reset_key;
		logic        fractional_divide_enable;
		logic [1:0]  divider_input_select;
		logic [3:0]  divide_n;
		logic [3:0]  divide_k;
		scm_sr_type  sr_state;
		logic        engine_reset;
		logic [4:0]  baud_count;
		logic [3:0]  frac_acc;
		logic        baud_tick;
		logic        rx_irq;
		logic        wr_pending;
		logic [7:0]  wr_offset;
		logic [31:0] rdata;
	} scm_state_type;

	scm_state_type state;
	scm_state_type next_state;

	// register read mux
	function automatic logic [31:0] read_word(input scm_state_type s, input logic [7:0] off);
		logic [31:0] w;
		w = '0;
		case (off)
			SCM_OFF_MODE0: w[7:0] = {2'b00, s.receive_enable, s.wake_up_enable,
				s.frame_mode, s.uart_clock_select};
			SCM_OFF_MODE1: w[7:0] = {s.idle_run, s.duplex_select, s.transmit_enable,
				s.tx_gap_interval, 1'b0};
			SCM_OFF_MODE2: w[7:0] = {s.tx_buffer_empty, s.rx_buffer_full, s.tx_active,
				s.stop_length, s.bit_order, s.double_buffer_enable, s.soft_reset_key};
			SCM_OFF_BAUD:  w[7:0] = {1'b0, s.fractional_divide_enable,
				s.divider_input_select, s.divide_n};
			SCM_OFF_FRAC:  w[7:0] = {4'h0, s.divide_k};
			default:       w = '0;
		endcase
		return w;
	endfunction

	// address phase and derived configuration
	logic        addr_valid;
	logic        uart_mode;
	logic        sync_mode;
	logic        tap_pulse;
	logic [4:0]  n_value;
	logic [4:0]  frac_sum;
	logic        frac_active;
	logic        frac_extra;
	logic [4:0]  period_len;
	logic        wr_now;
	logic [7:0]  wd;

	assign addr_valid = hsel & hready & (htrans == SCM_HTRANS_NSEQ || htrans == SCM_HTRANS_SEQ);
	assign uart_mode  = (state.frame_mode != SCM_MODE_SYNC);
	assign sync_mode  = ~uart_mode;
	assign wr_now     = state.wr_pending;
	assign wd         = hwdata[7:0];

	// prescaler tap selection for the divider
	always_comb
	begin
		case (state.divider_input_select)  // R18
			2'h0:    tap_pulse = tap_t1;
			2'h1:    tap_pulse = tap_t4;
			2'h2:    tap_pulse = tap_t16;
			2'h3:    tap_pulse = tap_t64;
			default: tap_pulse = 1'b0;
		endcase
	end

	// divisor and fractional stretch
	assign n_value     = (state.divide_n == SCM_N_SIXTEEN) ? SCM_N_ZERO_VAL
		: {1'b0, state.divide_n};  // R19
	assign frac_active = state.fractional_divide_enable & uart_mode;  // R20
	assign frac_sum    = {1'b0, state.frac_acc} + (SCM_FRAC_WRAP - {1'b0, state.divide_k});
	assign frac_extra  = frac_active & (frac_sum >= SCM_FRAC_WRAP);  // R20
	assign period_len  = n_value + {4'h0, frac_extra};

	// next state
	always_comb
	begin
		logic sr_fire;
		logic rd_mode2;
		sr_fire = 1'b0;
		rd_mode2 = 1'b0;
		next_state = state;
		next_state.engine_reset = 1'b0;
		next_state.baud_tick = 1'b0;
		next_state.rx_irq = 1'b0;

		// bus capture; read data is prepared during the address phase
		next_state.wr_pending = addr_valid & hwrite;
		if (addr_valid)
		begin
			next_state.wr_offset = haddr[7:0];
			next_state.rdata = read_word(state, haddr[7:0]);
			rd_mode2 = ~hwrite & (haddr[7:0] == SCM_OFF_MODE2);
		end
		else
		begin
			next_state.rdata = '0;
		end

		// register writes in the data phase
		if (wr_now)
		begin
			case (state.wr_offset)
				SCM_OFF_MODE0:
				begin
					next_state.receive_enable = wd[5];
					next_state.wake_up_enable = wd[4];
					next_state.frame_mode = wd[3:2];  // R2
					next_state.uart_clock_select = wd[1:0];  // R3
				end
				SCM_OFF_MODE1:
				begin
					next_state.idle_run = wd[7];  // R5
					next_state.duplex_select = wd[6:5];  // R6
					next_state.transmit_enable = wd[4];
					next_state.tx_gap_interval = wd[3:1];  // R8
				end
				SCM_OFF_MODE2:
				begin
					next_state.stop_length = wd[4];  // R12
					next_state.bit_order = wd[3];  // R13
					next_state.double_buffer_enable = wd[2];  // R14
					next_state.soft_reset_key = wd[1:0];
				end
				SCM_OFF_BAUD:
				begin
					next_state.fractional_divide_enable = wd[6];
					next_state.divider_input_select = wd[5:4];
					next_state.divide_n = wd[3:0];
				end
				SCM_OFF_FRAC:
				begin
					next_state.divide_k = wd[3:0];
				end
				default:
				begin
					next_state.wr_offset = state.wr_offset;
				end
			endcase
		end

		// soft reset key sequencer and delay
		case (state.sr_state)
			SCM_SR_IDLE:
			begin
				if (wr_now && state.wr_offset == SCM_OFF_MODE2 && wd[1:0] == SCM_KEY_ARM)
					next_state.sr_state = SCM_SR_ARMED;  // R15
			end
			SCM_SR_ARMED:
			begin
				if (wr_now && state.wr_offset == SCM_OFF_MODE2)
				begin
					if (wd[1:0] == SCM_KEY_FIRE)
						next_state.sr_state = SCM_SR_WAIT1;  // R15
					else if (wd[1:0] != SCM_KEY_ARM)
						next_state.sr_state = SCM_SR_IDLE;
				end
			end
			SCM_SR_WAIT1:
			begin
				next_state.sr_state = SCM_SR_WAIT2;  // R17
			end
			SCM_SR_WAIT2:
			begin
				next_state.sr_state = SCM_SR_IDLE;  // R17
				sr_fire = 1'b1;
			end
			default:
			begin
				next_state.sr_state = SCM_SR_IDLE;
			end
		endcase

		// status flags; hardware set wins over clear
		next_state.tx_active = tx_shifting;  // R11
		if (tx_buffer_write)
			next_state.tx_buffer_empty = 1'b0;  // R9
		if (tx_shift_load)
			next_state.tx_buffer_empty = 1'b1;  // R9
		if (rd_mode2)
			next_state.rx_buffer_full = 1'b0;  // R10
		if (rx_frame_done && rx_double_buffered)
			next_state.rx_buffer_full = 1'b1;  // R10

		// receive interrupt with wake-up filter
		if (rx_frame_done && rx_run_enable)
			next_state.rx_irq = ~(state.wake_up_enable && state.frame_mode == SCM_MODE_UART9)
				| rx_ninth_bit;  // R1

		// baud generator, counts selected prescaler taps while the channel runs
		if (channel_run && tap_pulse)
		begin
			if (state.baud_count + 5'h01 >= period_len)
			begin
				next_state.baud_count = '0;
				next_state.baud_tick = 1'b1;
				next_state.frac_acc = frac_active ? frac_sum[3:0] : 4'h0;  // R20
			end
			else
			begin
				next_state.baud_count = state.baud_count + 5'h01;
			end
		end

		// software reset takes over everything it names
		if (sr_fire)
		begin
			next_state.receive_enable = 1'b0;  // R15
			next_state.transmit_enable = 1'b0;  // R15
			next_state.tx_buffer_empty = 1'b0;  // R15
			next_state.rx_buffer_full = 1'b0;  // R15
			next_state.tx_active = 1'b0;  // R15
			next_state.engine_reset = 1'b1;  // R15
			next_state.baud_count = '0;
			next_state.frac_acc = '0;
		end
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state <= '0;
			state.sr_state <= SCM_SR_IDLE;
			state.tx_buffer_empty <= SCM_TX_BUFFER_EMPTY_RST;  // R9
		end
		else
		begin
			state <= next_state;
		end
	end

	// bus answers: zero wait, always okay
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = state.rdata;

	// channel run gating by idle state
	assign channel_run = state.idle_run | ~idle_mode;  // R5

	// transfer enables, duplex gating applies in sync mode only
	assign tx_run_enable = state.transmit_enable & channel_run
		& (uart_mode | state.duplex_select[1]);  // R6
	assign rx_run_enable = state.receive_enable & channel_run
		& (uart_mode | state.duplex_select[0]);  // R6

	// configuration passed to the shift engine
	assign frame_mode        = state.frame_mode;  // R2
	assign uart_clock_select = state.uart_clock_select;  // R3
	assign duplex_select     = state.duplex_select;
	assign tx_two_stop_bits  = uart_mode & state.stop_length;  // R12
	assign msb_first         = sync_mode & state.bit_order;  // R13
	assign tx_double_buffered = state.double_buffer_enable;  // R14
	assign rx_double_buffered = state.double_buffer_enable | uart_mode
		| sclk_input_sel;  // R14

	// gap between back-to-back sync transmissions with clock output
	always_comb
	begin
		if (sync_mode && !sclk_input_sel && state.double_buffer_enable
			&& state.tx_gap_interval != SCM_GAP_NONE)
			tx_gap_periods = 7'(7'h01 << (state.tx_gap_interval - 3'h1));  // R8
		else
			tx_gap_periods = 7'h00;
	end

	// registered strobes
	assign baud_tick    = state.baud_tick;
	assign rx_irq       = state.rx_irq;  // R1
	assign engine_reset = state.engine_reset;  // R15

endmodule

/* verif/scm_ctrl_asserts.sv */
// concurrent checks on the mode and baud control block ports
`timescale 1ns/1ps
module scm_ctrl_asserts
(
	// clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	// watched ports
	input wire logic       idle_mode,
	input wire logic       sclk_input_sel,
	input wire logic       rx_frame_done,
	input wire logic [1:0] frame_mode,
	input wire logic [1:0] duplex_select,
	input wire logic       tx_run_enable,
	input wire logic       rx_run_enable,
	input wire logic       channel_run,
	input wire logic       msb_first,
	input wire logic       rx_double_buffered,
	input wire logic [6:0] tx_gap_periods,
	input wire logic       baud_tick,
	input wire logic       rx_irq,
	input wire logic       engine_reset
);
	// single clock domain
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// output relations tied to their causes
	property p_irq_open;
		rx_frame_done && rx_run_enable && frame_mode != 2'h3 |=> rx_irq;
	endproperty
	a_irq_open: assert property (p_irq_open) else $error("irq missing");
	property p_irq_cause;
		rx_irq |-> $past(rx_frame_done);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq without frame");
	property p_idle;
		!idle_mode |-> channel_run;
	endproperty
	a_idle: assert property (p_idle) else $error("channel stopped");
	property p_duplex;
		frame_mode == 2'h0 |-> (!tx_run_enable || duplex_select[1])
			&& (!rx_run_enable || duplex_select[0]);
	endproperty
	a_duplex: assert property (p_duplex) else $error("duplex gating");
	property p_order;
		frame_mode != 2'h0 |-> !msb_first;
	endproperty
	a_order: assert property (p_order) else $error("msb first in uart");
	property p_rxbuf;
		frame_mode != 2'h0 || sclk_input_sel |-> rx_double_buffered;
	endproperty
	a_rxbuf: assert property (p_rxbuf) else $error("rx not buffered");
	property p_gap;
		$onehot0(tx_gap_periods) && (frame_mode == 2'h0 || tx_gap_periods == 7'h00);
	endproperty
	a_gap: assert property (p_gap) else $error("gap value");
	property p_sreset;
		engine_reset |-> !tx_run_enable && !rx_run_enable;
	endproperty
	a_sreset: assert property (p_sreset) else $error("enable after reset");
	// main scenarios reached
	cover property (rx_irq);
	cover property (engine_reset);
	cover property (baud_tick);
endmodule
bind scm_ctrl scm_ctrl_asserts u_chk (.clk, .rst_n, .idle_mode, .sclk_input_sel,
	.rx_frame_done, .frame_mode, .duplex_select, .tx_run_enable, .rx_run_enable,
	.channel_run, .msb_first, .rx_double_buffered, .tx_gap_periods, .baud_tick,
	.rx_irq, .engine_reset);

/* verif/scm_engine_model.sv */
// shift engine stand-in producing transmit and receive events
`timescale 1ns/1ps
module scm_engine_model
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// bench commands
	input wire logic send,
	input wire logic recv,
	input wire logic ninth,
	// engine events
	output logic     tx_buffer_write,
	output logic     tx_shift_load,
	output logic     tx_shifting,
	output logic     rx_frame_done,
	output logic     rx_ninth_bit
);
	int cnt;
	// buffer write, load after 20 cycles, then 20 cycles of shifting
	always @(posedge clk)
	begin
		tx_buffer_write <= send;
		rx_frame_done <= recv;
		rx_ninth_bit <= !rst_n ? 1'b0 : recv ? ninth : ~rx_ninth_bit;
		tx_shift_load <= cnt == 20;
		tx_shifting <= cnt > 20 && cnt <= 40;
		if (!rst_n || cnt >= 40)
			cnt <= 0;
		else if (send || cnt != 0)
			cnt <= send ? 1 : cnt + 1;
	end
endmodule

/* verif/test_serial_channel_mode_baud_control.sv */
// self-checking bench for the mode and baud control block
`timescale 1ns/1ps
module test_serial_channel_mode_baud_control
	import scm_pkg::*;
;
	logic        clk, rst_n, hsel, hwrite, hready, hreadyout, idle_mode, sclk_input_sel;
	logic        tap_t1, tap_t4, tap_t16, tap_t64, send, recv, ninth, tx_buffer_write;
	logic        tx_shift_load, tx_shifting, rx_frame_done, rx_ninth_bit, tx_run_enable;
	logic        rx_run_enable, channel_run, baud_tick, rx_irq, engine_reset;
	logic [1:0]  htrans, frame_mode, uart_clock_select;
	logic [2:0]  hsize;
	logic [6:0]  tx_gap_periods;
	logic [31:0] haddr, hwdata, hrdata, rd;
	int          failures, checked, ticks, irqs, cyc, n;

	assign hready = hreadyout;
	scm_ctrl uut (.*, .hresp(), .duplex_select(), .tx_two_stop_bits(), .msb_first(),
		.tx_double_buffered(), .rx_double_buffered());
	scm_engine_model u_eng (.*);

	// clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// prescaler taps of period 2, 8, 32, 128 and event counters
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		tap_t1 <= cyc[0];
		tap_t4 <= cyc[2:0] == 3'h7;
		tap_t16 <= cyc[4:0] == 5'h1F;
		tap_t64 <= cyc[6:0] == 7'h7F;
		if (baud_tick === 1'b1) ticks <= ticks + 1;
		if (rx_irq === 1'b1) irqs <= irqs + 1;
	end
	// single transfer, read data taken at the data-phase end edge, returns at the next falling edge
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= SCM_HTRANS_NSEQ;
		hwrite <= w;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		rd = hrdata;
		@(negedge clk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h0000_0000);
		chk(rd, exp);
	endtask
	// one-cycle command to the engine stand-in
	task automatic kick(input logic s, input logic r, input logic b);
		@(posedge clk);
		send <= s;
		recv <= r;
		ninth <= b;
		@(posedge clk);
		send <= 1'b0;
		recv <= 1'b0;
	endtask
	// ticks over two whole divider patterns, starting just after a tick
	task automatic baud(input logic [7:0] cfg, input logic [7:0] k, input int p16);
		bus(SCM_OFF_FRAC, 1'b1, {24'h00_0000, k});
		bus(SCM_OFF_BAUD, 1'b1, {24'h00_0000, cfg});
		n = ticks + 2;
		while (ticks < n) @(negedge clk);
		n = ticks;
		repeat (2 * p16) @(negedge clk);
		chk(ticks - n, 32);
	endtask
	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// watchdog
	initial
	begin
		#400000;
		failures++;
		report_and_stop;
	end
	// test sequence
	initial
	begin
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		idle_mode = 1'b0;
		sclk_input_sel = 1'b0;
		{tap_t1, tap_t4, tap_t16, tap_t64, send, recv, ninth} = 7'h00;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rdc(SCM_OFF_MODE0, 32'h0000_0000);
		rdc(SCM_OFF_BAUD, 32'h0000_0000);
		rdc(SCM_OFF_FRAC, 32'h0000_0000);
		rdc(SCM_OFF_MODE1, 32'h0000_0000);
		rdc(SCM_OFF_MODE2, 32'h0000_0080);
		bus(8'h20, 1'b1, 32'h0000_00FF);
		rdc(8'h20, 32'h0000_0000);
		$display("test reset values done");
		for (int i = 0; i < 4; i++)
		begin
			bus(SCM_OFF_MODE0, 1'b1, i * 5);
			chk({28'h000_0000, frame_mode, uart_clock_select}, i * 5);
		end
		$display("test mode fields done");
		bus(SCM_OFF_MODE0, 1'b1, 32'h0000_0020);
		bus(SCM_OFF_MODE2, 1'b1, 32'h0000_0004);
		for (int i = 0; i < 8; i++)
		begin
			bus(SCM_OFF_MODE1, 1'b1, 32'h10 | i << 1 | (i % 4) << 5);
			chk({25'h000_0000, tx_gap_periods}, i == 0 ? 0 : 1 << (i - 1));
			chk({30'h0000_0000, tx_run_enable, rx_run_enable}, i % 4);
		end
		$display("test gap and duplex done");
		kick(1'b1, 1'b0, 1'b0);
		rdc(SCM_OFF_MODE2, 32'h0000_0004);
		repeat (25) @(posedge clk);
		rdc(SCM_OFF_MODE2, 32'h0000_00A4);
		repeat (20) @(posedge clk);
		rdc(SCM_OFF_MODE2, 32'h0000_0084);
		kick(1'b0, 1'b1, 1'b0);
		rdc(SCM_OFF_MODE2, 32'h0000_00C4);
		rdc(SCM_OFF_MODE2, 32'h0000_0084);
		$display("test status flags done");
		for (int j = 0; j < 3; j++)
		begin
			bus(SCM_OFF_MODE0, 1'b1, j == 2 ? 32'h0000_0038 : 32'h0000_003C);
			n = irqs;
			kick(1'b0, 1'b1, j == 1);
			repeat (3) @(negedge clk);
			chk(irqs - n, j != 0);
		end
		$display("test wake filter done");
		@(posedge clk);
		idle_mode <= 1'b1;
		@(negedge clk);
		chk({31'h0000_0000, channel_run}, 32'h0000_0000);
		bus(SCM_OFF_MODE1, 1'b1, 32'h0000_00F0);
		chk({31'h0000_0000, channel_run}, 32'h0000_0001);
		@(posedge clk);
		idle_mode <= 1'b0;
		$display("test idle run done");
		bus(SCM_OFF_MODE0, 1'b1, 32'h0000_0020);
		bus(SCM_OFF_MODE2, 1'b1, 32'h0000_0006);
		bus(SCM_OFF_MODE2, 1'b1, 32'h0000_0005);
		n = 0;
		while (engine_reset !== 1'b1 && n < 9)
		begin
			@(negedge clk);
			n++;
		end
		chk(n, 2);
		rdc(SCM_OFF_MODE0, 32'h0000_0000);
		rdc(SCM_OFF_MODE1, 32'h0000_00E0);
		rdc(SCM_OFF_MODE2, 32'h0000_0005);
		// key sequence issued twice while a transmission is shifting out
		bus(SCM_OFF_MODE0, 1'b1, 32'h0000_0020);
		bus(SCM_OFF_MODE1, 1'b1, 32'h0000_00F0);
		kick(1'b1, 1'b0, 1'b0);
		repeat (25) @(posedge clk);
		for (int j = 0; j < 2; j++)
		begin
			bus(SCM_OFF_MODE2, 1'b1, 32'h0000_0006);
			bus(SCM_OFF_MODE2, 1'b1, 32'h0000_0005);
		end
		repeat (3) @(negedge clk);
		rdc(SCM_OFF_MODE0, 32'h0000_0000);
		rdc(SCM_OFF_MODE1, 32'h0000_00E0);
		$display("test soft reset done");
		baud(8'h00, 8'h00, 512);
		baud(8'h13, 8'h00, 384);
		baud(8'h21, 8'h00, 512);
		baud(8'h32, 8'h00, 4096);
		bus(SCM_OFF_MODE0, 1'b1, 32'h0000_0004);
		baud(8'h42, 8'h08, 80);
		$display("test baud divider done");
		report_and_stop;
	end
endmodule
